// ### tb.sv
// self-checking bench for the upstream misc config register bank
`timescale 1ns/1ps
module tb;
  import umc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] CTL [3] = '{32'h0000_010C, 32'h0000_000C, 32'h0000_010B};
  logic mclk = 0;
  logic reset_n = 0;
  logic [7:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  umc_ltssm_s ltssm_state = '0;
  umc_ident_load_s ident_load = '0;
  logic [1:0] wake_cap_enabled = 0;
  logic [2:0] pin_in = 3'h7;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  int fail_count = 0;
  int checked = 0;
  int seed = 88013;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] d;
  logic [31:0] v;
  always #25 mclk = ~mclk;
  umc_regs u_dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ltssm_state(ltssm_state), .ident_load(ident_load),
    .wake_cap_enabled(wake_cap_enabled), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  task automatic check(string n, logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // leading edge keeps a new request off the edge that released the last one
  task automatic bus(logic w, logic [7:0] a, logic [31:0] dt);
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= dt;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x, logic [31:0] m);
    exp_q.push_back({m, x});
    bus(0, a, 0);
  endtask
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      e = exp_q.pop_front();
      check("readdata", avs_readdata & e[63:32], e[31:0]);
    end
  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
      begin
        bus(1, 8'hAC, ALL);
        bus(1, 8'hB0, ALL);
        bus(1, 8'hB4, ALL);
      end
      rd(8'hAC, 32'h0, ALL);
      rd(8'hB0, 32'h0000_C00D, 32'h0000_FFFF);
      rd(8'hB4, 32'h0, ALL);
      rd(8'hB8, 32'h0000_0111, 32'h0000_01FF);
    end
    rd(8'h40, 32'h0, ALL);
    for (int c = 0; c < 3; c++)
    begin
      bus(1, 8'hA8, CTL[c]);
      for (int i = 0; i < 11; i++)
      begin
        ltssm_state <= umc_ltssm_s'(11'h400 >> i);
        rd(8'hAC, c == 0 ? 32'h1 << i : 32'h0, ALL);
      end
    end
    d = $random(seed);
    ident_load <= {d, 1'b1};
    @(posedge mclk);
    ident_load.load <= 1'b0;
    rd(8'hB4, d, ALL);
    for (int n = 0; n < 8; n++)
    begin
      d = $random(seed);
      v = $random(seed);
      pin_in <= v[2:0];
      wake_cap_enabled <= v[5:4];
      bus(1, 8'hB8, d);
      // pins pass three sync flops, so let them settle
      repeat (6) @(posedge mclk);
      check("pin_oe_n", {30'h0, pin_oe_n}, {30'h0, ~({d[5], d[1]} & ~v[5:4])});
      check("pin_out", {30'h0, pin_out}, {30'h0, d[6], d[2]});
      rd(8'hB8, {23'h0, v[2], 1'b0, d[6:5], v[1], 1'b0, d[2:1], v[0]}, 32'h0000_01FF);
    end
    @(posedge mclk);
    avs_read <= 1;
    avs_write <= 1;
    @(posedge mclk);
    avs_read <= 0;
    avs_write <= 0;
    repeat (4) @(posedge mclk);
    give_verdict;
  end
  initial
  begin
    #400000;
    fail_count++;
    give_verdict;
  end
endmodule

// ### umc_chk.sv
// checker for the upstream misc config register bank
`timescale 1ns/1ps
module umc_chk #(
  parameter int NUM_DRIVEN = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_DRIVEN-1:0] wake_cap_enabled,
  input wire logic [NUM_DRIVEN-1:0] pin_out,
  input wire logic [NUM_DRIVEN-1:0] pin_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire rd_ok = avs_read && !avs_waitrequest;
  AST_ANSWER: assert property ((avs_read ^ avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered");
  AST_ONE_LOW: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_BOTH: assert property (avs_read && avs_write |=> avs_waitrequest)
    else $error("read with write accepted");
  AST_CAP_ID: assert property (rd_ok && avs_address == 8'hB0 |-> avs_readdata[7:0] == 8'h0D)
    else $error("bad capability id");
  AST_CAP_NEXT: assert property (rd_ok && avs_address == 8'hB0 |-> avs_readdata[15:8] == 8'hC0)
    else $error("bad next pointer");
  AST_RSVD: assert property (rd_ok && avs_address == 8'hB8 |-> (avs_readdata & 32'h0000_0088) == 0)
    else $error("reserved pin bit set");
  AST_DBG_HI: assert property (rd_ok && avs_address == 8'hAC |-> avs_readdata[31:11] == 0)
    else $error("debug readout high bits set");
  // a pin may drive only while its wake capability was off
  AST_WAKE: assert property ((~pin_oe_n & $past(wake_cap_enabled)) == 0)
    else $error("pin driven with wake on");
  AST_RST: assert property ($rose(reset_n) |-> (&pin_oe_n) && pin_out == 0)
    else $error("pins not reset");
  CV_DBG: cover property (rd_ok && avs_address == 8'hAC && avs_readdata != 0);
  CV_DRIVE: cover property (~pin_oe_n != 0);
  CV_BOTH: cover property (avs_read && avs_write);
endmodule
bind umc_regs umc_chk #(.NUM_DRIVEN(NUM_DRIVEN)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wake_cap_enabled(wake_cap_enabled), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ### umc_pin_sync.sv
// three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
module umc_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level
);
  import umc_pkg::*;
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("width must be at least one");
    end
  end

  // inputs idle high, so reset to one avoids a false low after reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      pin_level <= '1;
    end
    else
    begin
      s1_reg <= pin_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          pin_level[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// ### umc_pkg.sv
// package for the upstream misc config register bank
package umc_pkg;
  localparam logic [7:0] UMC_DBG_CTRL_OFF = 8'h00_A8;
  localparam logic [7:0] UMC_DBG_READOUT_OFF = 8'h00_AC;
  localparam logic [7:0] UMC_SUBSYSTEM_DEVICE_IDENT_CAP_OFF = 8'h00_B0;
  localparam logic [7:0] UMC_SUBSYSTEM_DEVICE_IDENT_WORD_OFF = 8'h00_B4;
  localparam logic [7:0] UMC_PIN_IO_OFF = 8'h00_B8;
  localparam logic [31:0] UMC_DBG_READOUT_RST = 32'h0000_0000;
  localparam logic [4:0] UMC_DBG_VIEW_LTSSM = 5'h0C;
  localparam int UMC_DBG_START_BIT = 8;
  localparam logic [7:0] UMC_CAP_ID = 8'h0D;
  localparam logic [7:0] UMC_CAP_NEXT_RST = 8'hC0;
  localparam int UMC_PIN_FIELD_W = 4;
  localparam int UMC_PIN_IN_POS = 0;
  localparam int UMC_PIN_OE_POS = 1;
  localparam int UMC_PIN_OUT_POS = 2;
  localparam int UMC_LTSSM_W = 11;
  localparam int UMC_SYNC_STAGES = 3;

  typedef struct packed {
    logic detect;
    logic polling;
    logic config_st;
    logic l0_link_up;
    logic l0;
    logic l1;
    logic l2;
    logic disabled;
    logic hot_reset;
    logic loopback;
    logic recovery;
  } umc_ltssm_s;

  typedef struct packed {
    logic [15:0] device_ident;
    logic [15:0] vendor_ident;
    logic load;
  } umc_ident_load_s;
endpackage

// ### umc_regs.sv
// upstream misc config registers: debug readout, subsystem id, pin io
//
// Summary of operation
// - debug readout is a read-only word at offset ACh of the upstream port
// - debug readout holds selected debug data, resets to zero, ignores writes
// - view code 0Ch selects the one-hot link training state view
// - bits 0-4: detect, polling, configuration, L0 link up, L0
// - bits 5-10: L1, L2, disabled, hot reset, loopback, recovery
// - capability header low byte always reads 0Dh
// - capability header second byte is read-only next pointer, resets C0h
// - subsystem vendor id, low half, read-only, loadable by side channel
// - subsystem device id, high half, read-only, loadable by side channel
// - pin input bits follow pin level, reset to one
// - pin output enable bits select direction, reset to zero
// - pin output value bits drive an output pin, reset to zero
// - output value of pin 0/1 valid only with port 1/2 wake capability off
// - debug view applies only while start bit set, which resets to zero
`timescale 1ns/1ps
module umc_regs #(
  parameter int NUM_PINS = 3,
  parameter int NUM_DRIVEN = 2,
  parameter logic [15:0] VENDOR_IDENT_RST = 16'h0000,
  parameter logic [15:0] DEVICE_IDENT_RST = 16'h0000
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire umc_pkg::umc_ltssm_s ltssm_state,
  input wire umc_pkg::umc_ident_load_s ident_load,
  input wire logic [NUM_DRIVEN-1:0] wake_cap_enabled,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_DRIVEN-1:0] pin_out,
  output logic [NUM_DRIVEN-1:0] pin_oe_n
);
  import umc_pkg::*;

  // vendor/device ident arbitrary neutral defaults

  logic [4:0] dbg_view_reg;
  logic [2:0] dbg_port_reg;
  logic dbg_start_reg;
  logic [31:0] dbg_readout_reg;
  logic [15:0] vendor_ident_reg;
  logic [15:0] device_ident_reg;
  logic [NUM_DRIVEN-1:0] pin_oe_reg;
  logic [NUM_DRIVEN-1:0] pin_val_reg;
  logic [NUM_PINS-1:0] pin_level;
  logic ack_reg;
  logic [31:0] rd_next;
  logic [31:0] pin_word;
  logic wr_fire;
  logic rd_fire;

  initial
  begin
    if (NUM_PINS < NUM_DRIVEN || NUM_PINS * UMC_PIN_FIELD_W > 32 || NUM_DRIVEN < 1)
    begin
      $error("pin counts out of range");
    end
  end

  umc_pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin_async(pin_in),
    .pin_level(pin_level)
  );

  // one wait cycle per access: answer at the second edge, keeps readdata registered
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_fire = avs_write && !avs_read && ack_reg;
  assign rd_fire = avs_read && !avs_write && !ack_reg;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_reg <= (avs_read ^ avs_write) && !ack_reg;
      avs_waitrequest <= !((avs_read ^ avs_write) && !ack_reg);
    end
  end

  // debug control, kept at its neighbouring offset so the view can be chosen
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dbg_view_reg <= 5'h00;
      dbg_port_reg <= 3'h0;
      dbg_start_reg <= 1'b0;
    end
    else if (wr_fire && avs_address == UMC_DBG_CTRL_OFF)
    begin
      if (avs_byteenable[0])
      begin
        dbg_view_reg <= avs_writedata[4:0];
        dbg_port_reg <= avs_writedata[7:5];
      end
      if (avs_byteenable[1])
      begin
        dbg_start_reg <= avs_writedata[UMC_DBG_START_BIT];
      end
    end
  end

  // no bus write path at all: the readout follows hardware only
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dbg_readout_reg <= UMC_DBG_READOUT_RST;
    end
    else if (dbg_start_reg && dbg_view_reg == UMC_DBG_VIEW_LTSSM)
    begin
      dbg_readout_reg <= {21'h00_0000, ltssm_state[0], ltssm_state[1], ltssm_state[2],
        ltssm_state[3], ltssm_state[4], ltssm_state[5], ltssm_state[6], ltssm_state[7],
        ltssm_state[8], ltssm_state[9], ltssm_state[10]};
    end
    else
    begin
      dbg_readout_reg <= UMC_DBG_READOUT_RST;
    end
  end

  // ident loads from the side channel only; config writes never reach them
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vendor_ident_reg <= VENDOR_IDENT_RST;
      device_ident_reg <= DEVICE_IDENT_RST;
    end
    else if (ident_load.load)
    begin
      vendor_ident_reg <= ident_load.vendor_ident;
      device_ident_reg <= ident_load.device_ident;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_oe_reg <= '0;
      pin_val_reg <= '0;
    end
    else if (wr_fire && avs_address == UMC_PIN_IO_OFF && avs_byteenable[0])
    begin
      for (int i = 0; i < NUM_DRIVEN; i++)
      begin
        pin_oe_reg[i] <= avs_writedata[i * UMC_PIN_FIELD_W + UMC_PIN_OE_POS];
        pin_val_reg[i] <= avs_writedata[i * UMC_PIN_FIELD_W + UMC_PIN_OUT_POS];
      end
    end
  end

  // pin drivers; a pin whose wake capability is on is left undriven here
  genvar g;
  generate
    for (g = 0; g < NUM_DRIVEN; g++)
    begin : g_pin
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          pin_out[g] <= 1'b0;
          pin_oe_n[g] <= 1'b1;
        end
        else
        begin
          pin_out[g] <= pin_val_reg[g];
          pin_oe_n[g] <= !(pin_oe_reg[g] && !wake_cap_enabled[g]);
        end
      end
    end
  endgenerate

  always_comb
  begin
    pin_word = 32'h0000_0000;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_word[i * UMC_PIN_FIELD_W + UMC_PIN_IN_POS] = pin_level[i];
    end
    for (int i = 0; i < NUM_DRIVEN; i++)
    begin
      pin_word[i * UMC_PIN_FIELD_W + UMC_PIN_OE_POS] = pin_oe_reg[i];
      pin_word[i * UMC_PIN_FIELD_W + UMC_PIN_OUT_POS] = pin_val_reg[i];
    end
  end

  always_comb
  begin
    unique case (avs_address)
      UMC_DBG_CTRL_OFF:
        rd_next = {23'h00_0000, dbg_start_reg, dbg_port_reg, dbg_view_reg};
      UMC_DBG_READOUT_OFF:
        rd_next = dbg_readout_reg;
      UMC_SUBSYSTEM_DEVICE_IDENT_CAP_OFF:
        rd_next = {16'h0000, UMC_CAP_NEXT_RST, UMC_CAP_ID};
      UMC_SUBSYSTEM_DEVICE_IDENT_WORD_OFF:
        rd_next = {device_ident_reg, vendor_ident_reg};
      UMC_PIN_IO_OFF:
        rd_next = pin_word;
      default:
        rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      avs_readdata <= rd_next;
    end
  end
endmodule
